// ===== gated_timer.sv
// Gated 16-bit incrementing timer with an APB register port.
// Assumes pins and comparator outputs are asynchronous; the companion
// timer overflow pulse comes from logic on pclk.
`timescale 1ns/1ns
// Notes on behaviour
// R1: Count is 16 bits, incrementing only, read as high and low bytes.
// R2: Writing either count byte replaces those bits of the running count at once.
// R3: Run bit and gate enable bit together decide whether counting happens.
// R4: Gated counting advances only while the gate is active; ungated counts freely.
// R5: Software selects an internal source or the external pin as count clock.
// R6: Overflow sets a flag; wake only with external clock in asynchronous mode.
// R7: The count value is offered as time base to capture and compare units.
// R8: The selected count clock is output for comparator synchronisation.
// R9: Gate source comes from a two-bit select, with selectable polarity.
// R10: Every instance behaves the same; only names carry the instance numeral.
// R11: Source 11 low-freq osc, 10 external pin, 01 system, 00 system/4.
// R12: Prescaler divides by 1, 2, 4 or 8; cleared on count byte writes.
// R13: Gated, count rises on clock edges only while gate matches polarity, or in toggle mode while toggled open.
// R14: Gate source 00 pin, 01 companion timer overflow, others comparators.
// R15: Overflow flag sets on wrap from all ones, stays until software clears.
module gated_timer (
   // APB clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Count clock and gate sources
   input  wire logic        external_count_pin,
   input  wire logic        low_freq_internal_osc,
   input  wire logic        gate_pin,
   input  wire logic        comp1_out,
   input  wire logic        comp2_out,
   input  wire logic        tmr0_overflow_pulse,
   // Time base and events
   output logic      [15:0] count_value,
   output logic             count_clock_out,
   output logic             overflow_flag,
   output logic             wake_request
);

   // Register state.
   gate_timer_pkg::main_ctrl_s main_ctrl_ff;
   gate_timer_pkg::gate_ctrl_s gate_ctrl_ff;
   logic [15:0] count_ff;
   logic        overflow_flag_ff;
   logic        wake_ff;
   logic        clock_out_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;

   // Input conditioning.
   logic [4:0]  sync_q;
   logic        ext_sync;
   logic        low_freq_sync;
   logic        gate_pin_sync;
   logic        comp1_sync;
   logic        comp2_sync;
   logic        ext_prev_ff;
   logic        low_freq_prev_ff;
   logic [1:0]  quarter_ff;

   // Count clock path.
   logic        quarter_tick;
   logic        src_tick;
   logic        presc_tick;
   logic        count_write;
   logic        count_enable;
   logic        inc;
   logic        overflow_set;

   // Gate path.
   logic        gate_src;
   logic        gate_level;
   logic        toggle_ff;
   logic        level_prev_ff;
   logic        base_gate;
   logic        base_prev_ff;
   logic        base_rise;
   logic        base_fall;
   logic        pulse_open_ff;
   logic        gate_active;

   // Bus decode.
   logic        setup;
   logic        access;
   logic        wr_access;
   logic        wr_low;
   logic        wr_high;
   logic        wr_main;
   logic        wr_gate;
   logic        wr_status;
   logic [31:0] read_value;

   function automatic logic is_mapped(input logic [7:0] addr);
      case (addr)
         gate_timer_pkg::OFS_COUNT_LOW,
         gate_timer_pkg::OFS_COUNT_HIGH,
         gate_timer_pkg::OFS_MAIN_CTRL,
         gate_timer_pkg::OFS_GATE_CTRL,
         gate_timer_pkg::OFS_STATUS: is_mapped = 1'b1;
         default:                    is_mapped = 1'b0;
      endcase
   endfunction

   // Pins and comparator outputs cross into pclk here.
   sync2 #(
      .WIDTH(5)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({external_count_pin, low_freq_internal_osc, gate_pin, comp1_out, comp2_out}),
      .q       (sync_q)
   );

   assign {ext_sync, low_freq_sync, gate_pin_sync, comp1_sync, comp2_sync} = sync_q;

   // APB phases; every register answers with one wait-free access phase.
   assign setup     = psel && !penable;
   assign access    = psel && penable && pready_ff;
   assign wr_access = access && pwrite && !pslverr_ff;
   assign wr_low    = wr_access && (paddr == gate_timer_pkg::OFS_COUNT_LOW);
   assign wr_high   = wr_access && (paddr == gate_timer_pkg::OFS_COUNT_HIGH);
   assign wr_main   = wr_access && (paddr == gate_timer_pkg::OFS_MAIN_CTRL);
   assign wr_gate   = wr_access && (paddr == gate_timer_pkg::OFS_GATE_CTRL);
   assign wr_status = wr_access && (paddr == gate_timer_pkg::OFS_STATUS);

   always_comb begin
      case (paddr)
         gate_timer_pkg::OFS_COUNT_LOW:  read_value = {24'h0, count_ff[7:0]}; // R1
         gate_timer_pkg::OFS_COUNT_HIGH: read_value = {24'h0, count_ff[15:8]}; // R1
         gate_timer_pkg::OFS_MAIN_CTRL:  read_value = {24'h0, main_ctrl_ff};
         gate_timer_pkg::OFS_GATE_CTRL:  read_value = {24'h0, gate_ctrl_ff};
         gate_timer_pkg::OFS_STATUS:     read_value = {31'h0, overflow_flag_ff};
         default:                        read_value = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0;
      end else begin
         pready_ff  <= setup;
         pslverr_ff <= setup && !is_mapped(paddr);
         if (setup) begin
            prdata_ff <= pwrite ? 32'h0 : read_value;
         end
      end
   end

   // Control registers; reserved bits of the main register stay zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_ctrl_ff <= gate_timer_pkg::MAIN_CTRL_RESET;
      end else if (wr_main) begin
         main_ctrl_ff       <= pwdata[7:0]; // R5
         main_ctrl_ff.rsvd3 <= 1'b0;
         main_ctrl_ff.rsvd1 <= 1'b0;
      end
   end

   // The go flag is set by software and dropped when a single pulse ends.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_ctrl_ff <= gate_timer_pkg::GATE_CTRL_RESET;
      end else begin
         gate_ctrl_ff.gate_level_status <= gate_active;
         if (wr_gate) begin
            gate_ctrl_ff.gate_enable_bit       <= pwdata[7]; // R3
            gate_ctrl_ff.gate_polarity_bit     <= pwdata[6]; // R9
            gate_ctrl_ff.gate_toggle_bit       <= pwdata[5];
            gate_ctrl_ff.gate_single_pulse_bit <= pwdata[4];
            gate_ctrl_ff.gate_pulse_go_flag    <= pwdata[gate_timer_pkg::CTRL_GO_BIT];
            gate_ctrl_ff.gate_source_select    <= pwdata[1:0]; // R9
         end else if (pulse_open_ff && base_fall) begin
            gate_ctrl_ff.gate_pulse_go_flag <= 1'b0;
         end
      end
   end

   // Count clock sources, turned into one-cycle ticks on pclk.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quarter_ff       <= 2'h0;
         ext_prev_ff      <= 1'b0;
         low_freq_prev_ff <= 1'b0;
      end else begin
         quarter_ff       <= quarter_ff + 2'h1;
         ext_prev_ff      <= ext_sync;
         low_freq_prev_ff <= low_freq_sync;
      end
   end

   assign quarter_tick = (quarter_ff == gate_timer_pkg::QUARTER_LAST);

   always_comb begin
      case (main_ctrl_ff.clock_source_select)
         gate_timer_pkg::CS_SYS_QUARTER: src_tick = quarter_tick; // R11
         gate_timer_pkg::CS_SYS:         src_tick = 1'b1; // R11
         gate_timer_pkg::CS_EXT_PIN:     src_tick = ext_sync && !ext_prev_ff; // R11
         gate_timer_pkg::CS_LOW_FREQ:    src_tick = low_freq_sync && !low_freq_prev_ff; // R11
         default:                        src_tick = 1'b0;
      endcase
   end

   assign count_write = wr_low || wr_high;

   count_prescaler u_presc (
      .pclk            (pclk),
      .presetn         (presetn),
      .src_tick        (src_tick),
      .clear           (count_write), // R12
      .prescale_select (main_ctrl_ff.prescale_select),
      .tick            (presc_tick)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_out_ff <= 1'b0;
      end else begin
         clock_out_ff <= src_tick; // R8
      end
   end

   // Gate source and polarity: polarity zero counts while the source is low.
   always_comb begin
      case (gate_ctrl_ff.gate_source_select)
         gate_timer_pkg::GS_PIN:      gate_src = gate_pin_sync; // R14
         gate_timer_pkg::GS_TMR0_OVF: gate_src = tmr0_overflow_pulse; // R14
         gate_timer_pkg::GS_COMP1:    gate_src = comp1_sync; // R14
         gate_timer_pkg::GS_COMP2:    gate_src = comp2_sync; // R14
         default:                     gate_src = 1'b0;
      endcase
      gate_level = gate_ctrl_ff.gate_polarity_bit ? gate_src : !gate_src; // R9
   end

   // Toggle mode opens and closes the gate on alternate active edges.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         toggle_ff <= 1'b0;
      end else if (!gate_ctrl_ff.gate_toggle_bit) begin
         toggle_ff <= 1'b0;
      end else if (gate_level && !level_prev_ff) begin
         toggle_ff <= !toggle_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_prev_ff <= 1'b0;
         base_prev_ff  <= 1'b0;
      end else begin
         level_prev_ff <= gate_level;
         base_prev_ff  <= base_gate;
      end
   end

   assign base_gate = gate_ctrl_ff.gate_toggle_bit ? toggle_ff : gate_level;
   assign base_rise = base_gate && !base_prev_ff;
   assign base_fall = !base_gate && base_prev_ff;

   // Single pulse mode: once armed by go, one active window is let through.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_open_ff <= 1'b0;
      end else if (!gate_ctrl_ff.gate_single_pulse_bit || base_fall) begin
         pulse_open_ff <= 1'b0;
      end else if (gate_ctrl_ff.gate_pulse_go_flag && base_rise) begin
         pulse_open_ff <= 1'b1;
      end
   end

   assign gate_active = gate_ctrl_ff.gate_single_pulse_bit ? pulse_open_ff : base_gate; // R4

   // Counting decision.
   assign count_enable = main_ctrl_ff.run_bit &&
                         (!gate_ctrl_ff.gate_enable_bit || gate_active); // R3 R4 R13
   assign inc          = presc_tick && count_enable && !count_write; // R13
   assign overflow_set = inc && (count_ff == 16'hffff); // R15

   // The same counter logic serves each instance unchanged.
   always_ff @(posedge pclk or negedge presetn) begin // R10
      if (!presetn) begin
         count_ff <= gate_timer_pkg::COUNT_RESET;
      end else if (wr_low) begin
         count_ff[7:0] <= pwdata[7:0]; // R2
      end else if (wr_high) begin
         count_ff[15:8] <= pwdata[7:0]; // R2
      end else if (inc) begin
         count_ff <= count_ff + 16'h1; // R1
      end
   end

   // A wrap in the same cycle as a software clear keeps the flag set.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_flag_ff <= 1'b0;
      end else if (overflow_set) begin
         overflow_flag_ff <= 1'b1; // R6 R15
      end else if (wr_status && pwdata[gate_timer_pkg::STATUS_OVF_BIT]) begin
         overflow_flag_ff <= 1'b0; // R15
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_ff <= 1'b0;
      end else begin
         wake_ff <= overflow_set && main_ctrl_ff.async_input_select &&
                    (main_ctrl_ff.clock_source_select == gate_timer_pkg::CS_EXT_PIN); // R6
      end
   end

   assign prdata          = prdata_ff;
   assign pready          = pready_ff;
   assign pslverr         = pslverr_ff;
   assign count_value     = count_ff; // R7
   assign count_clock_out = clock_out_ff;
   assign overflow_flag   = overflow_flag_ff;
   assign wake_request    = wake_ff;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   ovf_set_a: assert property ( // R15
      overflow_set |=> overflow_flag_ff && count_ff == 16'h0000)
      else $error("overflow wrap did not set flag");
   ovf_hold_a: assert property ( // R15
      overflow_flag_ff && !(wr_status && pwdata[0]) |=> overflow_flag_ff)
      else $error("overflow flag dropped without clear");
   count_write_a: assert property ( // R2
      wr_low |=> count_ff[7:0] == $past(pwdata[7:0]) && $stable(count_ff[15:8]))
      else $error("low byte write not applied");
   count_mono_a: assert property ( // R1
      !count_write |=> count_ff == $past(count_ff) || count_ff == $past(count_ff) + 16'h1)
      else $error("count moved other than by one");
   count_off_a: assert property ( // R3
      !main_ctrl_ff.run_bit && !count_write |=> $stable(count_ff))
      else $error("count moved while stopped");
   gate_hold_a: assert property ( // R13
      gate_ctrl_ff.gate_enable_bit && !gate_active && !count_write |=> $stable(count_ff))
      else $error("count moved while gate inactive");
   sys_clock_a: assert property ( // R11
      main_ctrl_ff.run_bit && !gate_ctrl_ff.gate_enable_bit && !count_write &&
      main_ctrl_ff.clock_source_select == gate_timer_pkg::CS_SYS &&
      main_ctrl_ff.prescale_select == 2'h0 |=> count_ff == $past(count_ff) + 16'h1)
      else $error("system clock count missed a cycle");
   wake_a: assert property ( // R6
      wake_ff |-> overflow_flag_ff && main_ctrl_ff.async_input_select &&
      main_ctrl_ff.clock_source_select == gate_timer_pkg::CS_EXT_PIN)
      else $error("wake without asynchronous external overflow");
   clk_out_a: assert property ( // R8
      main_ctrl_ff.clock_source_select == gate_timer_pkg::CS_SYS ##1
      main_ctrl_ff.clock_source_select == gate_timer_pkg::CS_SYS |-> clock_out_ff)
      else $error("count clock output missing");
   apb_ready_a: assert property (
      setup |=> pready_ff ##1 !pready_ff)
      else $error("access phase answer not one cycle");

   ovf_c: cover property (overflow_set);
   gated_c: cover property (gate_ctrl_ff.gate_enable_bit && inc);
   wake_c: cover property (wake_ff);
   read_c: cover property (access && !pwrite && paddr == gate_timer_pkg::OFS_COUNT_HIGH);

endmodule

// ===== gate_timer_pkg.sv
// Constants, field layouts and register carriers for the gated 16-bit timer.
// Assumes a 32-bit APB register port with byte offsets held here.
package gate_timer_pkg;

   // Register byte offsets on the APB port.
   localparam logic [7:0] OFS_COUNT_LOW  = 8'h00;
   localparam logic [7:0] OFS_COUNT_HIGH = 8'h04;
   localparam logic [7:0] OFS_MAIN_CTRL  = 8'h08;
   localparam logic [7:0] OFS_GATE_CTRL  = 8'h0c;
   localparam logic [7:0] OFS_STATUS     = 8'h10;

   // Values after reset.
   localparam logic [15:0] COUNT_RESET     = 16'h0000;
   localparam logic [7:0]  MAIN_CTRL_RESET = 8'h00;
   localparam logic [7:0]  GATE_CTRL_RESET = 8'h00;

   // Clock source select encodings.
   localparam logic [1:0] CS_SYS_QUARTER = 2'h0;
   localparam logic [1:0] CS_SYS         = 2'h1;
   localparam logic [1:0] CS_EXT_PIN     = 2'h2;
   localparam logic [1:0] CS_LOW_FREQ    = 2'h3;

   // Gate source select encodings.
   localparam logic [1:0] GS_PIN      = 2'h0;
   localparam logic [1:0] GS_TMR0_OVF = 2'h1;
   localparam logic [1:0] GS_COMP1    = 2'h2;
   localparam logic [1:0] GS_COMP2    = 2'h3;

   // System clock divided by four: last phase of the quarter counter.
   localparam int         SYS_QUARTER_DIV = 4;
   localparam logic [1:0] QUARTER_LAST    = 2'(SYS_QUARTER_DIV - 1);

   // Status and gate control register bit positions.
   localparam int STATUS_OVF_BIT = 0;
   localparam int CTRL_GO_BIT    = 3;

   typedef struct packed {
      logic [1:0] clock_source_select;
      logic [1:0] prescale_select;
      logic       rsvd3;
      logic       async_input_select;
      logic       rsvd1;
      logic       run_bit;
   } main_ctrl_s;

   typedef struct packed {
      logic       gate_enable_bit;
      logic       gate_polarity_bit;
      logic       gate_toggle_bit;
      logic       gate_single_pulse_bit;
      logic       gate_pulse_go_flag;
      logic       gate_level_status;
      logic [1:0] gate_source_select;
   } gate_ctrl_s;

endpackage

// ===== sync2.sv
// Two-stage synchroniser for a bundle of independent level inputs.
// Assumes each bit is a slow level; no relation between bits is kept.
`timescale 1ns/1ns
module sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Levels
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= '0;
         q       <= '0;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule

// ===== count_prescaler.sv
// Prescaler that passes one of every 1, 2, 4 or 8 source ticks.
// Assumes src_tick is a one-cycle pulse on pclk.
`timescale 1ns/1ns
module count_prescaler (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Control
   input  wire logic       src_tick,
   input  wire logic       clear,
   input  wire logic [1:0] prescale_select,
   // Result
   output logic            tick
);
   logic [2:0] cnt_ff;
   logic [2:0] last;

   always_comb begin
      last = 3'(({3'h0, 1'b1} << prescale_select) - 4'h1);
      tick = src_tick && !clear && (cnt_ff >= last);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 3'h0;
      end else if (clear) begin
         cnt_ff <= 3'h0; // R12
      end else if (src_tick) begin
         cnt_ff <= (cnt_ff >= last) ? 3'h0 : cnt_ff + 3'h1; // R12
      end
   end

   presc_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
      clear |=> cnt_ff == 3'h0)
      else $error("prescaler not cleared by count write");
   presc_div8_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
      (tick && prescale_select == 2'h3 && !clear) |=> (prescale_select != 2'h3 || !tick) [*7])
      else $error("divide by eight ticked too early");
endmodule

// ===== timer_far_side.sv
// Far-side model: external count pin, slow oscillator and gate sources.
// Assumes the bench calls its tasks; levels change just after a rising pclk edge.
`timescale 1ns/1ns
module timer_far_side (
   // Clock
   input  wire logic pclk,
   // Count clock and gate sources
   output logic      external_count_pin,
   output logic      low_freq_internal_osc,
   output logic      gate_pin,
   output logic      comp1_out,
   output logic      comp2_out,
   output logic      tmr0_overflow_pulse
);
   initial begin
      external_count_pin = 1'b0;
      low_freq_internal_osc = 1'b0;
      gate_pin = 1'b0;
      comp1_out = 1'b0;
      comp2_out = 1'b0;
      tmr0_overflow_pulse = 1'b0;
   end

   // Gives n rising edges on one source; each level lasts half cycles, so a
   // large half models a slow source and a small one a prompt source.
   task automatic pulses(input bit osc, input int n, input int half);
      for (int i = 0; i < 2 * n; i++) begin
         repeat (half) @(posedge pclk);
         if (osc) low_freq_internal_osc <= ~low_freq_internal_osc;
         else external_count_pin <= ~external_count_pin;
      end
   endtask

   task automatic t0_pulses(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge pclk);
         tmr0_overflow_pulse <= 1'b1;
         @(posedge pclk);
         tmr0_overflow_pulse <= 1'b0;
      end
   endtask

   task automatic gates(input logic [2:0] lv);
      @(posedge pclk);
      {gate_pin, comp1_out, comp2_out} <= lv;
   endtask
endmodule

// ===== gated_timer_tb_top.sv
// Self-checking bench for the gated timer: APB master plus far-side model.
// Assumes a 10 MHz pclk and the register layout of the timer package.
`timescale 1ns/1ns
module gated_timer_tb_top;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        ext_pin;
   logic        lf_osc;
   logic        gate_pin;
   logic        comp1;
   logic        comp2;
   logic        t0_pulse;
   logic [15:0] count_value;
   logic        count_clock_out;
   logic        overflow_flag;
   logic        wake_request;
   int          error_cnt;
   int          n_compared;
   int          cyc;
   int          wake_cnt;

   gated_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .external_count_pin(ext_pin), .low_freq_internal_osc(lf_osc),
      .gate_pin(gate_pin), .comp1_out(comp1), .comp2_out(comp2),
      .tmr0_overflow_pulse(t0_pulse), .count_value(count_value),
      .count_clock_out(count_clock_out), .overflow_flag(overflow_flag),
      .wake_request(wake_request));
   timer_far_side i_far (.pclk(pclk), .external_count_pin(ext_pin),
      .low_freq_internal_osc(lf_osc), .gate_pin(gate_pin), .comp1_out(comp1),
      .comp2_out(comp2), .tmr0_overflow_pulse(t0_pulse));

   initial pclk = 1'b0;
   always #50 pclk = ~pclk;

   task automatic close_out;
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge pclk) begin
      if (wake_request === 1'b1) wake_cnt++;
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         $display("mismatch run length expected below 20000 seen %0d", cyc);
         close_out;
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      chk("access cycles", n, 1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask

   task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(what, r, {24'h0, exp});
   endtask

   function automatic logic [7:0] mc(input logic [1:0] cs, ps, input logic as, run);
      return {cs, ps, 1'b0, as, 1'b0, run};
   endfunction

   // Counts increments over a window; src 1 pulses the pin, 2 the slow osc, 3 the companion.
   task automatic delta(input string what, input int src, input int n, input int cyc_n,
                        input logic [15:0] exp);
      logic [15:0] a;
      @(negedge pclk);
      a = count_value;
      if (src == 1) i_far.pulses(1'b0, n, 3);
      if (src == 2) i_far.pulses(1'b1, n, 7);
      if (src == 3) i_far.t0_pulses(n);
      repeat (cyc_n) @(negedge pclk);
      chk(what, 16'(count_value - a), exp);
   endtask

   task automatic t_registers;
      logic [31:0] r;
      logic        e;
      rd("count low", gate_timer_pkg::OFS_COUNT_LOW, 8'h00);
      rd("count high", gate_timer_pkg::OFS_COUNT_HIGH, 8'h00);
      rd("main ctrl", gate_timer_pkg::OFS_MAIN_CTRL, 8'h00);
      rd("gate ctrl", gate_timer_pkg::OFS_GATE_CTRL, 8'h04);
      rd("status", gate_timer_pkg::OFS_STATUS, 8'h00);
      apb(1'b0, 8'h14, 32'h0, r, e);
      chk("unmapped err", e, 1);
      chk("unmapped data", r, 0);
      wr(gate_timer_pkg::OFS_COUNT_LOW, 8'h34);
      wr(gate_timer_pkg::OFS_COUNT_HIGH, 8'h12);
      rd("count low", gate_timer_pkg::OFS_COUNT_LOW, 8'h34);
      rd("count high", gate_timer_pkg::OFS_COUNT_HIGH, 8'h12);
      chk("time base", count_value, 16'h1234);
      wr(gate_timer_pkg::OFS_GATE_CTRL, 8'h80);
      delta("held while off", 0, 0, 16, 16'h0);
      $display("registers test done");
   endtask

   task automatic t_clocks;
      wr(gate_timer_pkg::OFS_GATE_CTRL, 8'h00);
      for (int ps = 0; ps < 4; ps++) begin
         wr(gate_timer_pkg::OFS_MAIN_CTRL, mc(gate_timer_pkg::CS_SYS, 2'(ps), 1'b0, 1'b1));
         delta("sys prescaled", 0, 0, 64, 16'(64 >> ps));
      end
      chk("count clock", count_clock_out, 1);
      wr(gate_timer_pkg::OFS_MAIN_CTRL, mc(gate_timer_pkg::CS_SYS_QUARTER, 0, 1'b0, 1'b1));
      delta("sys quarter", 0, 0, 64, 16'd16);
      wr(gate_timer_pkg::OFS_MAIN_CTRL, mc(gate_timer_pkg::CS_EXT_PIN, 0, 1'b0, 1'b1));
      delta("ext pin", 1, 5, 8, 16'd5);
      wr(gate_timer_pkg::OFS_MAIN_CTRL, mc(gate_timer_pkg::CS_LOW_FREQ, 0, 1'b0, 1'b1));
      delta("slow osc", 2, 4, 8, 16'd4);
      $display("clock source test done");
   endtask

   task automatic t_gate;
      wr(gate_timer_pkg::OFS_MAIN_CTRL, mc(gate_timer_pkg::CS_SYS, 0, 1'b0, 1'b1));
      for (int s = 0; s < 4; s++) begin
         for (int lv = 0; lv < 2; lv++) begin
            i_far.gates(lv != 0 ? 3'b111 : 3'b000);
            wr(gate_timer_pkg::OFS_GATE_CTRL, {6'b110000, 2'(s)});
            repeat (6) @(posedge pclk);
            delta("gated", 0, 0, 32, (s != 1 && lv != 0) ? 16'd32 : 16'd0);
         end
      end
      i_far.gates(3'b000);
      wr(gate_timer_pkg::OFS_GATE_CTRL, 8'h80);
      repeat (6) @(posedge pclk);
      delta("low polarity", 0, 0, 32, 16'd32);
      wr(gate_timer_pkg::OFS_GATE_CTRL, 8'he0);
      i_far.gates(3'b100);
      i_far.gates(3'b000);
      repeat (6) @(posedge pclk);
      delta("toggled", 0, 0, 32, 16'd32);
      wr(gate_timer_pkg::OFS_GATE_CTRL, 8'hd8);
      i_far.gates(3'b100);
      i_far.gates(3'b000);
      repeat (6) @(posedge pclk);
      rd("go cleared", gate_timer_pkg::OFS_GATE_CTRL, 8'hd0);
      wr(gate_timer_pkg::OFS_GATE_CTRL, 8'hc1);
      delta("companion ovf", 3, 4, 8, 16'd4);
      wr(gate_timer_pkg::OFS_GATE_CTRL, 8'h40);
      delta("ungated", 0, 0, 32, 16'd32);
      $display("gate test done");
   endtask

   task automatic t_overflow;
      wr(gate_timer_pkg::OFS_MAIN_CTRL, 8'h00);
      wr(gate_timer_pkg::OFS_GATE_CTRL, 8'h00);
      wr(gate_timer_pkg::OFS_COUNT_LOW, 8'hfe);
      wr(gate_timer_pkg::OFS_COUNT_HIGH, 8'hff);
      wr(gate_timer_pkg::OFS_MAIN_CTRL, mc(gate_timer_pkg::CS_SYS, 0, 1'b0, 1'b1));
      repeat (4) @(negedge pclk);
      wr(gate_timer_pkg::OFS_MAIN_CTRL, 8'h00);
      chk("overflow flag", overflow_flag, 1);
      rd("status set", gate_timer_pkg::OFS_STATUS, 8'h01);
      chk("no sync wake", wake_cnt, 0);
      wr(gate_timer_pkg::OFS_STATUS, 8'h01);
      rd("status clear", gate_timer_pkg::OFS_STATUS, 8'h00);
      wr(gate_timer_pkg::OFS_COUNT_LOW, 8'hff);
      wr(gate_timer_pkg::OFS_COUNT_HIGH, 8'hff);
      wr(gate_timer_pkg::OFS_MAIN_CTRL, mc(gate_timer_pkg::CS_EXT_PIN, 0, 1'b1, 1'b1));
      delta("wrap by pin", 1, 1, 8, 16'd1);
      chk("async wake", wake_cnt, 1);
      chk("overflow again", overflow_flag, 1);
      wr(gate_timer_pkg::OFS_MAIN_CTRL, 8'h00);
      $display("overflow test done");
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_registers;
      t_clocks;
      t_gate;
      t_overflow;
      close_out;
   end
endmodule
